// file: src/ufc_frame_timer.sv
// frame remaining and frame number counters with register access
`include "ufc_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module ufc_frame_timer
   import ufc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        arst_n,
   // register access from the pci target
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic [31:0]      reg_rdata,
   output logic             reg_hit,
   // frame interval register fields
   // nominal interval from outside
   input  wire logic [13:0] interval_length,
   input  wire logic        interval_toggle_bit,
   // controller in operational state
   input  wire logic        operational_state,
   // start-of-frame token request
   output logic             sof_pulse,
   // communication area write port
   output logic             hca_wr_valid,
   input  wire logic        hca_wr_ready,
   output logic [15:0]      hca_wr_data,
   // frame start event toward interrupt status
   output logic             frame_start_flag_set,
   // descriptor fetch allowed for this frame
   output logic             ed_fetch_ok
);
   logic [13:0]  bit_times_left;       // remaining count
   logic         remaining_toggle_bit; // copied interval toggle
   logic [15:0]  frame_count;          // frame number counter
   logic         oper_q;               // previous operational level
   logic         enter_oper;           // operational entry pulse
   logic         tick;                 // one bit time elapsed
   logic         reload;               // frame boundary reload
   logic         hca_busy;             // writer holding a request
   logic         hca_done;             // writer finished
   ufc_seq_e     seq;                  // frame sequencer state
   ufc_hca_req_s hca_req;              // request to the writer
   ufc_reg_req_s req;                  // bundled access

   assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

   // decode of a register offset
   function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
      is_ofs = (a == o);
   endfunction

   // bit time generator
   ufc_bit_tick u_tick
   (
      .clock  (clock),
      .arst_n (arst_n),
      .run    (operational_state),
      .tick   (tick)
   );

   // operational entry edge
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         oper_q <= 1'b0;
      else
         oper_q <= operational_state;
   end
   assign enter_oper = operational_state && !oper_q;

   // reload when zero at a bit boundary
   assign reload = operational_state && !enter_oper && tick && (bit_times_left == `UFC_FR_ZERO);

   // remaining counter and toggle
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bit_times_left       <= `UFC_FR_ZERO;
         remaining_toggle_bit <= 1'b0;
      end
      else if (enter_oper)
      begin
         bit_times_left <= interval_length;
      end
      else if (reload)
      begin
         bit_times_left <= interval_length;
         remaining_toggle_bit <= interval_toggle_bit;
      end
      else if (operational_state && tick)
      begin
         bit_times_left <= bit_times_left - 14'h0001;
      end
      else if (req.wr && is_ofs(req.addr, `UFC_OFS_REMAINING))
      begin
         bit_times_left       <= req.wdata[`UFC_FR_W-1:0];
         remaining_toggle_bit <= req.wdata[`UFC_TOGGLE_BIT];
      end
   end

   // frame number counter
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         frame_count <= '0;
      else if (enter_oper || reload)
         frame_count <= frame_count + `UFC_FN_ONE;
      else if (req.wr && is_ofs(req.addr, `UFC_OFS_NUMBER))
         frame_count <= {2'b00, req.wdata[`UFC_FR_W-1:0]};
   end

   // frame sequencer: sof, then publish, then allow fetch
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         seq <= UFC_IDLE;
      else
      begin
         unique case (seq)
            UFC_IDLE:
               if (reload)
                  seq <= UFC_SOF;
            UFC_SOF:
               seq <= UFC_WRITE;
            UFC_WRITE:
               if (hca_done)
                  seq <= UFC_IDLE;
            default:
               seq <= UFC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         sof_pulse <= 1'b0;
      else
         sof_pulse <= reload;
   end

   assign hca_req = '{valid: (seq == UFC_SOF), count: frame_count};
   // no fetch while the count write is still pending
   assign ed_fetch_ok = (seq == UFC_IDLE) && !hca_busy && operational_state;

   ufc_hca_writer u_hca
   (
      .clock        (clock),
      .arst_n       (arst_n),
      .req          (hca_req),
      .busy         (hca_busy),
      .hca_wr_valid (hca_wr_valid),
      .hca_wr_ready (hca_wr_ready),
      .hca_wr_data  (hca_wr_data),
      .done         (hca_done)
   );

   // one-cycle set of status bit 2
   assign frame_start_flag_set = hca_done;

   // read data register; reserved bits read zero
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_rdata <= '0;
         reg_hit   <= 1'b0;
      end
      else if (req.rd && is_ofs(req.addr, `UFC_OFS_REMAINING))
      begin
         reg_rdata <= {remaining_toggle_bit, 17'h00000, bit_times_left};
         reg_hit   <= 1'b1;
      end
      else if (req.rd && is_ofs(req.addr, `UFC_OFS_NUMBER))
      begin
         reg_rdata <= {18'h00000, frame_count[`UFC_FR_W-1:0]};
         reg_hit   <= 1'b1;
      end
      else
      begin
         reg_rdata <= '0;
         reg_hit   <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: src/ufc_consts.svh
// constants and contract for the frame timing counters
`ifndef UFC_CONSTS_SVH
`define UFC_CONSTS_SVH
`define UFC_ADDR_W          8
`define UFC_OFS_REMAINING   8'h38
`define UFC_OFS_NUMBER      8'h3C
`define UFC_FR_W            14
`define UFC_FN_W            16
`define UFC_TOGGLE_BIT      31
`define UFC_FI_RESET        14'h2EDF
`define UFC_FR_ZERO         14'h0000
`define UFC_FN_ONE          16'h0001
`define UFC_SF_BIT          2
`define UFC_CLK_HZ          125000000
`define UFC_BIT_HZ          12000000
`define UFC_BT_ACC_W        28
`define UFC_BT_INC          28'h000000C
`define UFC_BT_MOD          28'h000007D
`endif

// file: src/ufc_pkg.sv
// types for the frame timing counters
package ufc_pkg;
   // register access strobe bundle
   typedef struct packed
   {
      logic        wr;     // write strobe
      logic        rd;     // read strobe
      logic [7:0]  addr;   // byte offset
      logic [31:0] wdata;  // write data
   } ufc_reg_req_s;
   // communication area write request
   typedef struct packed
   {
      logic        valid;  // request pending
      logic [15:0] count;  // frame count to publish
   } ufc_hca_req_s;
   // frame sequencer states
   typedef enum logic [2:0]
   {
      UFC_IDLE  = 3'b001,
      UFC_SOF   = 3'b010,
      UFC_WRITE = 3'b100
   } ufc_seq_e;
endpackage

// file: src/ufc_bit_tick.sv
// bit time tick generator from the system clock
`include "ufc_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module ufc_bit_tick
   import ufc_pkg::*;
(
   input  wire logic clock,
   input  wire logic arst_n,
   input  wire logic run,
   output logic      tick
);
   logic [`UFC_BT_ACC_W-1:0] acc;       // fractional phase accumulator
   logic [`UFC_BT_ACC_W-1:0] next_acc;  // accumulator plus increment

   // 12/125 ratio scaled so bits carry exact average rate
   always_comb
   begin
      next_acc = acc + `UFC_BT_INC;
   end

   // accumulate phase; one tick per bit time
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         acc  <= '0;
         tick <= 1'b0;
      end
      else if (!run)
      begin
         acc  <= '0;
         tick <= 1'b0;
      end
      else if (next_acc >= `UFC_BT_MOD)
      begin
         acc  <= next_acc - `UFC_BT_MOD;
         tick <= 1'b1;
      end
      else
      begin
         acc  <= next_acc;
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: src/ufc_hca_writer.sv
// publishes the frame count and raises the frame start event
`include "ufc_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module ufc_hca_writer
   import ufc_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         arst_n,
   input  wire ufc_hca_req_s req,
   output logic              busy,
   output logic              hca_wr_valid,
   input  wire logic         hca_wr_ready,
   output logic [15:0]       hca_wr_data,
   output logic              done
);
   // hold the request until the memory side accepts it
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hca_wr_valid <= 1'b0;
         hca_wr_data  <= '0;
      end
      else if (req.valid && !hca_wr_valid)
      begin
         hca_wr_valid <= 1'b1;
         hca_wr_data  <= req.count;
      end
      else if (hca_wr_valid && hca_wr_ready)
      begin
         hca_wr_valid <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         done <= 1'b0;
      else
         done <= hca_wr_valid && hca_wr_ready;
   end

   assign busy = hca_wr_valid;
endmodule
`default_nettype wire

// file: verif/ufc_frame_timer_properties.sv
// assertion checker for the frame timing counters
`timescale 1ns/1ns
`default_nettype none
module ufc_frame_timer_chk
(
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic        reg_hit,
   input wire logic [13:0] interval_length,
   input wire logic        interval_toggle_bit,
   input wire logic        operational_state,
   input wire logic        sof_pulse,
   input wire logic        hca_wr_valid,
   input wire logic        hca_wr_ready,
   input wire logic [15:0] hca_wr_data,
   input wire logic        frame_start_flag_set,
   input wire logic        ed_fetch_ok
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   unmapped_read_a: assert property (reg_rd && reg_addr != 8'h38 && reg_addr != 8'h3C
      |=> !reg_hit && reg_rdata == 32'h0) else $error("unmapped read answered");
   mapped_read_a: assert property (reg_rd && (reg_addr == 8'h38 || reg_addr == 8'h3C) |=> reg_hit)
      else $error("mapped read not answered");
   write_after_sof_a: assert property (sof_pulse |-> ##1 hca_wr_valid)
      else $error("count write missing after frame start");
   write_holds_a: assert property (hca_wr_valid && !hca_wr_ready |=> hca_wr_valid && $stable(hca_wr_data))
      else $error("count write dropped");
   flag_after_write_a: assert property (hca_wr_valid && hca_wr_ready |=> frame_start_flag_set && !hca_wr_valid)
      else $error("flag not set after write");
   flag_cause_a: assert property (frame_start_flag_set |-> $past(hca_wr_valid && hca_wr_ready))
      else $error("flag without write");
   flag_pulse_a: assert property (frame_start_flag_set |=> !frame_start_flag_set)
      else $error("flag longer than a cycle");
   sof_pulse_a: assert property (sof_pulse |=> (!sof_pulse)[*2])
      else $error("frame start repeated");
   idle_frozen_a: assert property (!operational_state |=> !sof_pulse)
      else $error("frame start while idle");
   fetch_wait_a: assert property (hca_wr_valid |-> !ed_fetch_ok)
      else $error("fetch before count write");
endmodule
`default_nettype wire

// file: verif/ufc_frame_timer_tb.sv
// self-checking bench for the frame timing counters
`timescale 1ns/1ns
`default_nettype none
`include "ufc_consts.svh"
module ufc_frame_timer_tb;
   import ufc_pkg::*;
   logic clock, arst_n, reg_wr, reg_rd, reg_hit, interval_toggle_bit, operational_state;
   logic sof_pulse, hca_wr_valid, hca_wr_ready, frame_start_flag_set, ed_fetch_ok, h;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d, r0;
   logic [13:0] interval_length;
   logic [15:0] hca_wr_data;
   int fails, n_compared;
   time t0;
   ufc_frame_timer i_ufc_frame_timer
   (
      .clock                (clock),
      .arst_n               (arst_n),
      .reg_wr               (reg_wr),
      .reg_rd               (reg_rd),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_rdata            (reg_rdata),
      .reg_hit              (reg_hit),
      .interval_length      (interval_length),
      .interval_toggle_bit  (interval_toggle_bit),
      .operational_state    (operational_state),
      .sof_pulse            (sof_pulse),
      .hca_wr_valid         (hca_wr_valid),
      .hca_wr_ready         (hca_wr_ready),
      .hca_wr_data          (hca_wr_data),
      .frame_start_flag_set (frame_start_flag_set),
      .ed_fetch_ok          (ed_fetch_ok)
   );
   initial
   begin
      clock = 0;
      forever #4 clock = ~clock;
   end
   task give_verdict;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] s, e);
      n_compared++;
      if (s !== e)
      begin
         fails++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task step;
      @(posedge clock);
      #1;
   endtask
   // one register access then an idle edge; answer taken in the cycle it stands
   task acc(input logic w, input logic [7:0] a, input logic [31:0] v);
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = v;
      step;
      d = reg_rdata;
      h = reg_hit;
      reg_wr = 0;
      reg_rd = 0;
      step;
   endtask
   // bounded wait for frame start (0) or count write (1)
   task wt(input bit v);
      int n;
      n = 0;
      while ((v ? hca_wr_valid : sof_pulse) !== 1'b1)
      begin
         step;
         n++;
         if (n > 300)
         begin
            fails++;
            give_verdict;
         end
      end
   endtask
   // accept the count write after some stall cycles
   task ack(input logic [15:0] e, input int st);
      wt(1);
      chk(hca_wr_data, e);
      repeat (st) step;
      hca_wr_ready = 1;
      step;
      hca_wr_ready = 0;
      chk(frame_start_flag_set, 1);
      chk(ed_fetch_ok, 0);
      step;
      chk(frame_start_flag_set, 0);
      chk(ed_fetch_ok, 1);
   endtask
   task t_regs;
      acc(0, 8'h38, 0);
      chk(d, 0);
      chk(h, 1);
      acc(0, 8'h3C, 0);
      chk(d, 0);
      acc(0, 8'h40, 0);
      chk(h, 0);
      chk(d, 0);
      acc(1, 8'h3C, 32'h3FFE);
      acc(0, 8'h3C, 0);
      chk(d, 32'h3FFE);
      acc(1, 8'h38, 32'h10);
      acc(0, 8'h38, 0);
      chk(d, 32'h10);
      $display("t_regs done");
   endtask
   task t_frames;
      interval_length = 5;
      interval_toggle_bit = 1;
      operational_state = 1;
      step;
      step;
      acc(0, 8'h3C, 0);
      chk(d, 32'h3FFF);
      wt(0);
      t0 = $time;
      interval_length = 9;
      interval_toggle_bit = 0;
      ack(16'h4000, 3);
      acc(0, 8'h38, 0);
      chk(d[31], 1);
      chk(d[13:0] <= 5, 1);
      acc(0, 8'h3C, 0);
      chk(d, 0);
      wt(0);
      chk((($time - t0) / 8) inside {[62:63]}, 1);
      t0 = $time;
      ack(16'h4001, 0);
      wt(0);
      chk((($time - t0) / 8) inside {[104:105]}, 1);
      ack(16'h4002, 1);
      acc(0, 8'h38, 0);
      chk(d[31], 0);
      operational_state = 0;
      step;
      acc(0, 8'h38, 0);
      r0 = d;
      repeat (40) step;
      acc(0, 8'h38, 0);
      chk(d, r0);
      // bench plays the interval register at its reset value
      interval_length = `UFC_FI_RESET;
      operational_state = 1;
      step;
      acc(0, 8'h38, 0);
      chk(d, `UFC_FI_RESET);
      acc(0, 8'h3C, 0);
      chk(d, 32'h00000003);
      operational_state = 0;
      $display("t_frames done");
   endtask
   initial
   begin
      {reg_wr, reg_rd, reg_addr, reg_wdata, hca_wr_ready} = 0;
      {interval_length, interval_toggle_bit, operational_state} = 0;
      arst_n = 0;
      repeat (20) @(posedge clock);
      #1;
      arst_n = 1;
      step;
      t_regs;
      t_frames;
      give_verdict;
   end
endmodule
bind ufc_frame_timer ufc_frame_timer_chk i_ufc_frame_timer_chk
(
   .clock                (clock),
   .arst_n               (arst_n),
   .reg_wr               (reg_wr),
   .reg_rd               (reg_rd),
   .reg_addr             (reg_addr),
   .reg_wdata            (reg_wdata),
   .reg_rdata            (reg_rdata),
   .reg_hit              (reg_hit),
   .interval_length      (interval_length),
   .interval_toggle_bit  (interval_toggle_bit),
   .operational_state    (operational_state),
   .sof_pulse            (sof_pulse),
   .hca_wr_valid         (hca_wr_valid),
   .hca_wr_ready         (hca_wr_ready),
   .hca_wr_data          (hca_wr_data),
   .frame_start_flag_set (frame_start_flag_set),
   .ed_fetch_ok          (ed_fetch_ok)
);
`default_nettype wire
